// File: rtu_slave_defs.vh
// constants for the serial request handler
`ifndef RTU_SLAVE_DEFS_VH
`define RTU_SLAVE_DEFS_VH
// function codes
`define FC_RD_HOLD    8'h03
`define FC_WR_SINGLE  8'h06
`define FC_WR_COILS   8'h0F
`define FC_WR_MULTI   8'h10
`define FC_RD_WR      8'h17
`define FC_EXC_FLAG   8'h80
// exception codes
`define EXC_NONE      8'h00
`define EXC_FUNC      8'h01
`define EXC_ADDR      8'h02
`define EXC_VALUE     8'h03
// station addresses
`define ADDR_BCAST    8'h00
// implemented space
`define NUM_REGS      17'h00040
`define REG_AW        6
`define NUM_COILS     17'h00040
`define COIL_AW       6
// quantity limits per request
`define MAX_RD_QTY    16'h007D
`define MAX_WR_QTY    16'h007B
`define MAX_COIL_QTY  16'h07B0
// frame store
`define FRAME_MAX     8'hFF
`define MIN_FRAME     8'h04
// request field positions
`define POS_BCNT      8'h06
`define POS_DATA_MULT 8'h07
`define POS_DATA_SGL  8'h04
`define POS_RW_WSTART 8'h06
`define POS_RW_BCNT   8'h0A
`define POS_RW_DATA   8'h0B
// reply lengths without crc
`define LEN_ECHO      8'h06
`define LEN_EXC       8'h03
`define LEN_RD_HDR    8'h03
// crc-16
`define CRC_INIT      16'hFFFF
`define CRC_POLY      16'hA001
`endif

// File: rtu_slave.v
// serial request handler: decode, execute and answer register and coil telegrams
// Behaviour
// - write coils from force data bits
// - broadcast coil write forces coils too
// - coil write reply echoes address and count
// - read returns current holding register contents
// - wire register addresses are zero based
// - read data high byte then low byte
// - single preset writes one register
// - single preset reply echoes, after write
// - multiple preset writes consecutive registers
// - multiple preset reply echoes start, count
// - combined function: one write, one read
// - combined function writes before reading
// - combined reply carries read data only
// - byte count equals read bytes following
// - out of range start+length gives 02
// - broadcast reads ignored, never answered
// - coil bits packed lsb first
`timescale 1ns/10ps
`default_nettype none
`include "rtu_slave_defs.vh"
module rtu_slave (
  input  wire        i_clk,       // system clock
  input  wire        i_rst,       // synchronous reset, high
  input  wire [7:0]  i_slave_addr, // own station address
  input  wire [7:0]  i_rx_data,   // received byte
  input  wire        i_rx_valid,  // received byte strobe
  input  wire        i_rx_end,    // end of frame strobe
  input  wire        i_tx_ready,  // transmitter takes byte
  output reg         o_rx_ready,  // accepting frame bytes
  output reg  [7:0]  o_tx_data,   // reply byte
  output reg         o_tx_valid,  // reply byte valid
  output reg         o_tx_last,   // last byte of reply
  output reg  [63:0] o_coils      // coil image
);
  localparam [2:0] ST_RX    = 3'h0;  // collecting frame
  localparam [2:0] ST_CHECK = 3'h1;  // crc, address, decode
  localparam [2:0] ST_WRITE = 3'h2;  // one write per cycle
  localparam [2:0] ST_SEND  = 3'h3;  // pushing reply bytes

  // crc-16 over one byte, reflected polynomial
  function [15:0] crc_step;
    input [15:0] c;
    input [7:0]  b;
    integer k;
    reg [15:0] t;
    begin
      t = c ^ {8'h00, b};
      for (k = 0; k < 8; k = k + 1) begin
        t = t[0] ? ((t >> 1) ^ `CRC_POLY) : (t >> 1);
      end
      crc_step = t;
    end
  endfunction

  reg [7:0]  rxb [0:255];       // frame store
  reg [15:0] hreg [0:63];       // holding registers
  reg [2:0]  state_q;           // sequencer state
  reg [7:0]  len_q;             // bytes stored
  reg        ovf_q;             // frame too long
  reg [15:0] crc_q;             // receive crc
  reg [15:0] tcrc_q;            // transmit crc
  reg [7:0]  fn_q;              // function code
  reg [7:0]  exc_q;             // exception to report
  reg        rd_q;              // reply carries read data
  reg        coil_q;            // write goes to coils
  reg        bcast_q;           // broadcast frame
  reg [15:0] wst_q;             // write start
  reg [15:0] wq_q;              // write quantity
  reg [7:0]  wb_q;              // write data position
  reg [15:0] rs_q;              // read start
  reg [15:0] rq_q;              // read quantity
  reg [7:0]  idx_q;             // write index
  reg [7:0]  j_q;               // reply byte index
  reg [7:0]  txlen_q;           // reply length without crc
  reg [8:0]  head_q;            // buffer tail entry {last,data}
  reg        tail_v_q;          // tail entry valid
  // decode of the stored request
  reg [15:0] s;
  reg [15:0] q;
  reg [15:0] wst;
  reg [15:0] wq;
  reg [7:0]  wb;
  reg [7:0]  exc;
  reg        rd;
  reg        wr;
  reg        coil;
  reg [7:0]  cbytes;
  reg [16:0] wend;
  always @* begin
    s = {rxb[2], rxb[3]};        // zero based start
    q = {rxb[4], rxb[5]};        // high byte first
    wst = s;
    wq = q;
    wb = `POS_DATA_MULT;
    exc = `EXC_NONE;
    rd = 1'b0;
    wr = 1'b0;
    coil = 1'b0;
    cbytes = q[10:3] + {7'h00, |q[2:0]};
    wend = {1'b0, s} + {1'b0, q};
    case (rxb[1])
      `FC_WR_COILS: begin
        wr = 1'b1;
        coil = 1'b1;
        if (q == 16'h0000 || q > `MAX_COIL_QTY || rxb[`POS_BCNT] != cbytes) begin
          exc = `EXC_VALUE;
        end else if (wend > `NUM_COILS) begin
          exc = `EXC_ADDR;
        end
      end
      `FC_RD_HOLD: begin
        rd = 1'b1;
        if (q == 16'h0000 || q > `MAX_RD_QTY) begin
          exc = `EXC_VALUE;
        end else if (wend > `NUM_REGS) begin
          exc = `EXC_ADDR;
        end
      end
      `FC_WR_SINGLE: begin
        wr = 1'b1;
        wq = 16'h0001;
        wb = `POS_DATA_SGL;
        if ({1'b0, s} >= `NUM_REGS) begin
          exc = `EXC_ADDR;
        end
      end
      `FC_WR_MULTI: begin
        wr = 1'b1;
        if (q == 16'h0000 || q > `MAX_WR_QTY || rxb[`POS_BCNT] != {q[6:0], 1'b0}) begin
          exc = `EXC_VALUE;
        end else if (wend > `NUM_REGS) begin
          exc = `EXC_ADDR;
        end
      end
      `FC_RD_WR: begin
        rd = 1'b1;
        wr = 1'b1;
        wst = {rxb[`POS_RW_WSTART], rxb[`POS_RW_WSTART + 8'h01]};
        wq = {rxb[`POS_RW_WSTART + 8'h02], rxb[`POS_RW_WSTART + 8'h03]};
        wb = `POS_RW_DATA;
        if (q == 16'h0000 || q > `MAX_RD_QTY || wq == 16'h0000 || wq > `MAX_WR_QTY
            || rxb[`POS_RW_BCNT] != {wq[6:0], 1'b0}) begin
          exc = `EXC_VALUE;
        end else if (wend > `NUM_REGS || ({1'b0, wst} + {1'b0, wq}) > `NUM_REGS) begin
          exc = `EXC_ADDR;
        end
      end
      default: begin
        exc = `EXC_FUNC;         // unsupported function
      end
    endcase
  end
  // reply byte for the current index
  reg [7:0]  tbyte;
  reg [7:0]  roff;
  reg [15:0] rword;
  reg [15:0] ra;
  always @* begin
    roff = j_q - `LEN_RD_HDR;
    ra = rs_q + {9'h000, roff[7:1]};
    rword = hreg[ra[`REG_AW-1:0]];          // sampled after writes
    tbyte = rxb[j_q];                       // echo of request head
    if (j_q == txlen_q) begin
      tbyte = tcrc_q[7:0];                  // crc low first
    end else if (j_q == txlen_q + 8'h01) begin
      tbyte = tcrc_q[15:8];
    end else if (exc_q != `EXC_NONE) begin
      if (j_q == 8'h01) begin
        tbyte = fn_q | `FC_EXC_FLAG;
      end else if (j_q == 8'h02) begin
        tbyte = exc_q;
      end
    end else if (rd_q && j_q == 8'h02) begin
      tbyte = {rq_q[6:0], 1'b0};            // byte count of data
    end else if (rd_q && j_q > 8'h02) begin
      tbyte = roff[0] ? rword[7:0] : rword[15:8];  // high then low
    end
  end
  // two-entry reply buffer: head drives the port, tail absorbs a stall
  wire       buf_ready = ~tail_v_q;
  wire       push = (state_q == ST_SEND) && buf_ready;
  wire       push_last = (j_q == txlen_q + 8'h01);
  wire       pop = o_tx_valid & i_tx_ready;
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_tx_valid <= 1'b0;
      o_tx_data <= 8'h00;
      o_tx_last <= 1'b0;
      tail_v_q <= 1'b0;
      head_q <= 9'h000;
    end else begin
      if (!o_tx_valid || pop) begin
        if (tail_v_q) begin                 // tail moves up
          {o_tx_last, o_tx_data} <= head_q;
          o_tx_valid <= 1'b1;
          tail_v_q <= 1'b0;
        end else begin                      // fresh byte or empty
          {o_tx_last, o_tx_data} <= {push_last, tbyte};
          o_tx_valid <= push;
        end
      end else if (push) begin              // head stalled, park in tail
        head_q <= {push_last, tbyte};
        tail_v_q <= 1'b1;
      end
    end
  end
  // holding register writes, no reset on the array
  wire [15:0] wa = wst_q + {8'h00, idx_q};
  wire [7:0]  dpos = wb_q + {idx_q[6:0], 1'b0};
  wire [7:0]  cpos = wb_q + {3'h0, idx_q[7:3]};
  always @(posedge i_clk) begin
    if (state_q == ST_WRITE && !coil_q) begin
      hreg[wa[`REG_AW-1:0]] <= {rxb[dpos], rxb[dpos + 8'h01]};
    end
  end
  // frame store
  always @(posedge i_clk) begin
    if (state_q == ST_RX && i_rx_valid && len_q != `FRAME_MAX) begin
      rxb[len_q] <= i_rx_data;
    end
  end
  // main sequencer
  always @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= ST_RX;
      len_q <= 8'h00;
      ovf_q <= 1'b0;
      crc_q <= `CRC_INIT;
      tcrc_q <= `CRC_INIT;
      fn_q <= 8'h00;
      exc_q <= `EXC_NONE;
      rd_q <= 1'b0;
      coil_q <= 1'b0;
      bcast_q <= 1'b0;
      wst_q <= 16'h0000;
      wq_q <= 16'h0000;
      wb_q <= 8'h00;
      rs_q <= 16'h0000;
      rq_q <= 16'h0000;
      idx_q <= 8'h00;
      j_q <= 8'h00;
      txlen_q <= 8'h00;
      o_coils <= 64'h0000000000000000;
      o_rx_ready <= 1'b1;
    end else begin
      case (state_q)
        ST_RX: begin
          if (i_rx_valid) begin
            if (len_q != `FRAME_MAX) begin
              len_q <= len_q + 8'h01;
              crc_q <= crc_step(crc_q, i_rx_data);
            end else begin
              ovf_q <= 1'b1;
            end
          end
          if (i_rx_end) begin
            state_q <= ST_CHECK;
            o_rx_ready <= 1'b0;
          end
        end
        ST_CHECK: begin
          len_q <= 8'h00;
          ovf_q <= 1'b0;
          crc_q <= `CRC_INIT;
          tcrc_q <= `CRC_INIT;
          idx_q <= 8'h00;
          j_q <= 8'h00;
          fn_q <= rxb[1];
          exc_q <= exc;
          rd_q <= rd;
          coil_q <= coil;
          bcast_q <= (rxb[0] == `ADDR_BCAST);
          wst_q <= wst;
          wq_q <= wq;
          wb_q <= wb;
          rs_q <= s;
          rq_q <= q;
          txlen_q <= (exc != `EXC_NONE) ? `LEN_EXC :
                     rd ? (`LEN_RD_HDR + {q[6:0], 1'b0}) : `LEN_ECHO;
          if (crc_q != 16'h0000 || ovf_q || len_q < `MIN_FRAME) begin
            state_q <= ST_RX;               // bad frame dropped silently
            o_rx_ready <= 1'b1;
          end else if (rxb[0] != i_slave_addr && rxb[0] != `ADDR_BCAST) begin
            state_q <= ST_RX;
            o_rx_ready <= 1'b1;
          end else if (rxb[0] == `ADDR_BCAST && (rd || exc != `EXC_NONE)) begin
            state_q <= ST_RX;
            o_rx_ready <= 1'b1;
          end else if (exc != `EXC_NONE) begin
            state_q <= ST_SEND;             // exception reply, nothing written
          end else if (wr) begin
            state_q <= ST_WRITE;            // broadcast writes too
          end else begin
            state_q <= ST_SEND;
          end
        end
        ST_WRITE: begin
          if (coil_q) begin
            o_coils[wa[`COIL_AW-1:0]] <= rxb[cpos][idx_q[2:0]];
          end
          idx_q <= idx_q + 8'h01;
          if ({8'h00, idx_q} == wq_q - 16'h0001) begin
            if (bcast_q) begin
              state_q <= ST_RX;
              o_rx_ready <= 1'b1;
            end else begin
              state_q <= ST_SEND;           // write done before reply or read
            end
          end
        end
        ST_SEND: begin
          if (push) begin
            j_q <= j_q + 8'h01;
            if (j_q < txlen_q) begin
              tcrc_q <= crc_step(tcrc_q, tbyte);
            end
            if (push_last) begin
              state_q <= ST_RX;
              o_rx_ready <= 1'b1;
            end
          end
        end
        default: begin
          state_q <= ST_RX;
          o_rx_ready <= 1'b1;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// File: rtu_slave_properties.sv
// assertion checker for the request handler ports
`timescale 1ns/10ps
`default_nettype none
module rtu_slave_props (
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_rx_end,
  input wire logic        i_tx_ready,
  input wire logic        o_rx_ready,
  input wire logic [7:0]  o_tx_data,
  input wire logic        o_tx_valid,
  input wire logic        o_tx_last,
  input wire logic [63:0] o_coils
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  property p_hold; o_tx_valid && !i_tx_ready |=>
    o_tx_valid && $stable({o_tx_data, o_tx_last}); endproperty
  a_hold: assert property (p_hold) else $error("stalled reply byte changed");
  property p_busy; o_rx_ready && i_rx_end |=> !o_rx_ready; endproperty
  a_busy: assert property (p_busy) else $error("frame end not taken up");
  property p_first; $rose(o_tx_valid) |-> !o_rx_ready; endproperty
  a_first: assert property (p_first) else $error("reply outside a frame");
  property p_quiet; o_rx_ready && !o_tx_valid |=> !o_tx_valid; endproperty
  a_quiet: assert property (p_quiet) else $error("reply without request");
  property p_gap; o_tx_valid && o_tx_last && i_tx_ready |=> !o_tx_valid; endproperty
  a_gap: assert property (p_gap) else $error("byte after last byte");
  property p_coil; $changed(o_coils) |-> !$past(o_rx_ready); endproperty
  a_coil: assert property (p_coil) else $error("coils changed while idle");
  property p_short; $rose(o_tx_valid) |-> !o_tx_last [*4]; endproperty
  a_short: assert property (p_short) else $error("reply shorter than five bytes");
  property p_back; $fell(o_rx_ready) |-> ##[1:1000] o_rx_ready; endproperty
  a_back: assert property (p_back) else $error("frame never finished");
endmodule
bind rtu_slave rtu_slave_props u_props (.i_clk(i_clk), .i_rst(i_rst), .i_rx_end(i_rx_end),
  .i_tx_ready(i_tx_ready), .o_rx_ready(o_rx_ready), .o_tx_data(o_tx_data),
  .o_tx_valid(o_tx_valid), .o_tx_last(o_tx_last), .o_coils(o_coils));
`default_nettype wire

// File: rtu_master.sv
// behavioural bus master feeding request frames byte by byte
`timescale 1ns/10ps
`default_nettype none
module rtu_master (
  input  wire logic       i_clk,
  input  wire logic       i_idle,
  output var  logic [7:0] o_data,
  output var  logic       o_valid,
  output var  logic       o_end
);
  initial begin
    o_data = 8'h00;
    o_valid = 1'b0;
    o_end = 1'b0;
  end
  // wait for the slave, then one byte a cycle, end strobe with the last
  task automatic send(input logic [7:0] b[$]);
    while (i_idle !== 1'b1) begin
      @(posedge i_clk);
      #1;
    end
    foreach (b[k]) begin
      o_data = b[k];
      o_valid = 1'b1;
      o_end = (k == b.size() - 1);
      @(posedge i_clk);
      #1;
    end
    o_data = ~o_data; // no stale byte on a released line
    o_valid = 1'b0;
    o_end = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: rtu_slave_tb.sv
// self-checking bench for the request handler
`timescale 1ns/10ps
`default_nettype none
module rtu_slave_tb;
  localparam logic [7:0] own_addr = 8'h21; // station address
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic        i_tx_ready = 1'b0;
  logic [7:0]  rx_data, o_tx_data;
  logic        rx_valid, rx_end, o_rx_ready, o_tx_valid, o_tx_last;
  logic [63:0] o_coils;
  logic [63:0] cmdl = 64'h0;
  logic [15:0] mdl [0:63];
  logic [15:0] seed = 16'h6180;
  logic [8:0]  exp_q [$];
  logic [7:0]  f [$], r [$];
  bit          corrupt = 1'b0;
  int          bad_count = 0, check_count = 0, cyc = 0;
  rtu_slave u_dut (.i_clk(i_clk), .i_rst(i_rst), .i_slave_addr(own_addr),
    .i_rx_data(rx_data), .i_rx_valid(rx_valid), .i_rx_end(rx_end), .i_tx_ready(i_tx_ready),
    .o_rx_ready(o_rx_ready), .o_tx_data(o_tx_data), .o_tx_valid(o_tx_valid),
    .o_tx_last(o_tx_last), .o_coils(o_coils));
  rtu_master u_mst (.i_clk(i_clk), .i_idle(o_rx_ready), .o_data(rx_data),
    .o_valid(rx_valid), .o_end(rx_end));
  always #12.5 i_clk = ~i_clk;
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction
  function automatic logic [15:0] crc(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i]) begin
      c = c ^ {8'h00, q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction
  function automatic bit acts(input logic [7:0] sa);
    return !corrupt && (sa == own_addr || sa == 8'h00);
  endfunction
  task automatic tick();
    @(posedge i_clk);
    #1;
  endtask
  task automatic fail(input string m);
    bad_count++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic chk_coils();
    check_count++;
    if (o_coils !== cmdl) fail("coil image mismatch");
  endtask
  task automatic results();
    if (bad_count == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // random receiver stalls and hang guard
  always @(posedge i_clk) begin
    #1;
    void'(rnd());
    i_tx_ready = |seed[1:0];
    cyc++;
    if (cyc == 40000) begin
      fail("timeout");
      results();
    end
  end
  // taken reply byte against the oldest note
  task automatic chk_byte();
    check_count++;
    if (exp_q.size() == 0) fail("reply byte without request");
    else if ({o_tx_last, o_tx_data} !== exp_q.pop_front()) fail("reply byte mismatch");
  endtask
  // each reply byte against the oldest note
  always @(posedge i_clk) begin
    if (o_tx_valid === 1'b1 && i_tx_ready === 1'b1) chk_byte();
  end
  // seal request and reply with crc, send, wait until all is answered
  task automatic xfer(input logic [7:0] sa);
    logic [15:0] c;
    c = crc(f) ^ {15'h0000, corrupt};
    f = {f, c[7:0], c[15:8]};
    if (sa == own_addr && !corrupt) begin
      c = crc(r);
      r = {r, c[7:0], c[15:8]};
      foreach (r[k]) exp_q.push_back({k == r.size() - 1, r[k]});
    end
    u_mst.send(f);
    while (o_rx_ready !== 1'b1 || exp_q.size() != 0) tick();
  endtask
  task automatic w6(input logic [7:0] sa, input logic [15:0] ad);
    logic [15:0] v;
    v = rnd();
    f = {sa, 8'h06, ad[15:8], ad[7:0], v[15:8], v[7:0]};
    r = f;
    if (acts(sa)) mdl[ad] = v;
    xfer(sa);
  endtask
  task automatic wr(input logic [7:0] fn, sa, input logic [15:0] rs, rq, ws, wq);
    logic [15:0] v;
    bit ok;
    ok = (fn == 8'h03 || ws + wq <= 64) && (fn == 8'h10 || rs + rq <= 64);
    f = {sa, fn};
    if (fn != 8'h10) f = {f, rs[15:8], rs[7:0], rq[15:8], rq[7:0]};
    if (fn != 8'h03) f = {f, ws[15:8], ws[7:0], wq[15:8], wq[7:0], 8'(2 * wq)};
    for (int i = 0; i < wq && fn != 8'h03; i++) begin
      v = rnd();
      f = {f, v[15:8], v[7:0]};
      if (ok && acts(sa)) mdl[ws + i] = v;
    end
    if (!ok) r = {sa, fn | 8'h80, 8'h02};
    else if (fn == 8'h10) r = f[0:5];
    else r = {sa, fn, 8'(2 * rq)};
    for (int i = 0; i < rq && ok && fn != 8'h10; i++)
      r = {r, mdl[rs + i][15:8], mdl[rs + i][7:0]};
    xfer(sa);
  endtask
  task automatic wc(input logic [7:0] sa, input logic [15:0] st, q);
    logic [7:0] d;
    bit ok;
    ok = st + q <= 64;
    f = {sa, 8'h0F, st[15:8], st[7:0], q[15:8], q[7:0], 8'((q + 7) / 8)};
    for (int i = 0; i < q; i++) begin
      if (i % 8 == 0) d = 8'(rnd());
      if (i % 8 == 0) f.push_back(d);
      if (ok && acts(sa)) cmdl[st + i] = d[i % 8];
    end
    if (ok) r = f[0:5];
    else r = {sa, 8'h8F, 8'h02};
    xfer(sa);
    chk_coils();
  endtask
  // a request that must be refused with the given exception code
  task automatic xc(input logic [7:0] fn, input logic [15:0] q, input logic [7:0] code);
    f = {own_addr, fn, 8'h00, 8'h00, q[15:8], q[7:0]};
    r = {own_addr, fn | 8'h80, code};
    xfer(own_addr);
  endtask
  initial begin
    repeat (20) tick();
    i_rst = 1'b0;
    chk_coils();
    wr(8'h10, own_addr, 0, 0, 0, 64);
    w6(own_addr, 0);
    wr(8'h03, own_addr, 0, 1, 0, 0);
    wr(8'h10, own_addr, 0, 0, 60, 4);
    wr(8'h03, own_addr, 60, 4, 0, 0);
    wr(8'h17, own_addr, 30, 3, 30, 3);
    wr(8'h03, own_addr, 61, 4, 0, 0);
    wr(8'h10, own_addr, 0, 0, 63, 2);
    wr(8'h17, own_addr, 63, 2, 0, 1);
    xc(8'h01, 16'h0001, 8'h01);
    xc(8'h03, 16'h0000, 8'h03);
    xc(8'h03, 16'h007E, 8'h03);
    xc(8'h03, 16'h007D, 8'h02);
    wc(own_addr, 3, 13);
    wc(8'h00, 40, 24);
    wc(own_addr, 56, 8);
    wc(own_addr, 60, 5);
    w6(own_addr, 1);
    corrupt = 1'b1;
    w6(own_addr, 1);
    corrupt = 1'b0;
    w6(own_addr + 8'h01, 1);
    w6(8'h00, 2);
    wr(8'h03, own_addr, 0, 3, 0, 0);
    wr(8'h03, 8'h00, 0, 1, 0, 0);
    repeat (6) wr(8'h17, own_addr, rnd() % 56, 8, rnd() % 56, 1 + rnd() % 8);
    repeat (30) tick();
    results();
  end
endmodule
`default_nettype wire
